/* rtl/acls_pkg.sv */
// Package for the audio configuration and link status register bank
`default_nettype none
package acls_pkg;

  // Register offsets on the serial control bus register port
  localparam logic [7:0] ACLS_ADDR_BRIDGE_CONTROL     = 8'h54;
  localparam logic [7:0] ACLS_ADDR_AUDIO_FIFO_CONTROL = 8'h55;
  localparam logic [7:0] ACLS_ADDR_LINK_STATUS        = 8'h5A;

  // Bridge control field positions (low bits only)
  localparam int ACLS_BC_TDM_ENABLE   = 2;
  localparam int ACLS_BC_AUDIO_SOURCE = 1;
  localparam int ACLS_BC_EXTRA_CHAN   = 0;

  // Audio FIFO control field positions
  localparam int ACLS_AF_TDM_TO_PARALLEL = 7;
  localparam int ACLS_AF_PIN_OUTPUT      = 6;
  localparam int ACLS_AF_RESET_ON_TYPE   = 3;
  localparam int ACLS_AF_RESET_ON_AIF    = 2;
  localparam int ACLS_AF_RESET_ON_AVI    = 1;
  localparam int ACLS_AF_RESET_ON_ACR    = 0;

  // Link status field positions
  localparam int ACLS_LS_LINK_READY = 7;
  localparam int ACLS_LS_TX_ACTIVE  = 6;
  localparam int ACLS_LS_PORT_HI    = 5;
  localparam int ACLS_LS_PORT_LO    = 4;
  localparam int ACLS_LS_TMDS       = 3;
  localparam int ACLS_LS_PLL_LOCK   = 2;
  localparam int ACLS_LS_NO_CLOCK   = 1;
  localparam int ACLS_LS_FREQ_OK    = 0;

  // Writable masks and reset values
  localparam logic [7:0] ACLS_BRIDGE_CONTROL_MASK  = 8'h07;
  localparam logic [7:0] ACLS_AUDIO_FIFO_MASK      = 8'hCF;
  localparam logic [7:0] ACLS_BRIDGE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ACLS_AUDIO_FIFO_RESET     = 8'h0C;
  localparam logic [7:0] ACLS_LINK_STATUS_RESET    = 8'h00;
  localparam logic [7:0] ACLS_READ_UNMAPPED        = 8'h00;

  // Port mode encodings reported while transmitting
  typedef enum logic [1:0] {
    ACLS_PORT_DUAL      = 2'h0,
    ACLS_PORT_SINGLE_P0 = 2'h1,
    ACLS_PORT_SINGLE_P1 = 2'h2,
    ACLS_PORT_REPLICATE = 2'h3
  } acls_port_mode_e;

  // Live conditions from the link, receiver and frequency detector
  typedef struct packed {
    logic            link_ready;
    logic            tx_active;
    logic            downstream_locked;
    logic            input_valid;
    logic            mode_entered;
    acls_port_mode_e port_mode;
    logic            tmds_recovered;
    logic            pll_locked;
    logic            no_clock;
    logic            freq_settled;
  } acls_live_s;

  // Change events seen by the bridge controller, one-cycle pulses
  typedef struct packed {
    logic audio_type;
    logic audio_infoframe;
    logic video_infoframe;
    logic clock_regen;
  } acls_events_s;

  // Settings driven into the audio path and transmitter
  typedef struct packed {
    logic tdm_enable;
    logic audio_source_local;
    logic extra_channel_enable;
    logic tdm_to_parallel_enable;
    logic use_converter_clock;
    logic audio_pin_output_enable;
  } acls_audio_ctl_s;

endpackage
`default_nettype wire

/* rtl/acls_regs.sv */
// Audio configuration and link status register bank
//
// How it works
// - Bridge control bit 2 enables TDM carriage of audio extracted from video.
// - Source select: 0 takes video-input audio, 1 takes local serial audio.
// - Extra channel enable adds a second 2-channel audio stream downstream.
// - Extra channel enable loads from the mode strap pin after reset.
// - Audio config bit 7 enables converter and selects its clock for audio.
// - Audio config bit 6 drives video-input audio onto serial audio pins.
// - Pin output enable is ignored unless the audio source is video input.
// - Bit 3 resets the input audio FIFO on audio type change.
// - Bit 2 resets the FIFO on audio infoframe checksum change.
// - Bit 1 resets the FIFO on video infoframe checksum change.
// - Bit 0 resets the FIFO on clock regeneration N or CTS change.
// - Status bit 7 shows downstream connection found and capabilities known.
// - Status bit 6 shows transmitter active with receiver locked.
// - Transmit-active only after valid input and correct mode entered.
// - Status 5:4 reports port mode while transmit-active, else zero.
// - Status bit 3 shows TMDS data recovered; first revision reads one.
// - Status bit 2 shows input PLL locked to incoming video clock.
// - Status bit 1 shows no input clock above low-frequency threshold.
// - Status bit 0 shows input clock frequency settled.
`default_nettype none
`timescale 1ns/1ps
module acls_regs
  import acls_pkg::*;
#(
  parameter bit TMDS_ALWAYS_VALID = 1'b1
) (
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  input  wire logic            strap_pin_zero_i,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic            reg_write_i,
  input  wire logic [7:0]      reg_wdata_i,
  input  wire logic            reg_read_i,
  input  wire acls_live_s      live_i,
  input  wire acls_events_s    events_i,
  output logic [7:0]           reg_rdata_o,
  output logic                 reg_rvalid_o,
  output acls_audio_ctl_s      audio_ctl_o,
  output logic                 fifo_reset_o
);

  if ($bits(live_i.port_mode) != 2) begin : g_check
    $error("Port mode field must be two bits wide");
  end

  typedef struct packed {
    logic [7:0]      bridge_control;
    logic [7:0]      audio_fifo_control;
    logic [7:0]      link_status;
    logic [7:0]      rdata;
    logic            rvalid;
    logic            strap_pending;
    logic            fifo_reset;
    acls_audio_ctl_s ctl;
  } acls_state_s;

  acls_state_s state;
  acls_state_s next_state;

  logic tx_ok;
  logic [7:0] live_status;
  logic [7:0] bc_next;
  logic [7:0] af_next;

  // Transmit-active needs every precondition at once, not just the transmitter
  assign tx_ok = live_i.tx_active & live_i.downstream_locked
               & live_i.input_valid & live_i.mode_entered;

  always_comb begin
    live_status = ACLS_LINK_STATUS_RESET;
    live_status[ACLS_LS_LINK_READY] = live_i.link_ready;
    live_status[ACLS_LS_TX_ACTIVE]  = tx_ok;
    if (tx_ok) begin
      live_status[ACLS_LS_PORT_HI:ACLS_LS_PORT_LO] = live_i.port_mode;
    end
    // First silicon could not report loss of TMDS data
    live_status[ACLS_LS_TMDS] = TMDS_ALWAYS_VALID
                              | live_i.tmds_recovered;
    live_status[ACLS_LS_PLL_LOCK] = live_i.pll_locked;
    live_status[ACLS_LS_NO_CLOCK] = live_i.no_clock;
    live_status[ACLS_LS_FREQ_OK]  = live_i.freq_settled;
  end

  always_comb begin
    next_state = state;
    bc_next = state.bridge_control;
    af_next = state.audio_fifo_control;
    next_state.link_status = live_status;
    next_state.rvalid = 1'b0;
    next_state.fifo_reset = 1'b0;

    // Strap is caught one cycle after reset release, never under reset
    if (state.strap_pending) begin
      bc_next[ACLS_BC_EXTRA_CHAN] = strap_pin_zero_i;
      next_state.strap_pending = 1'b0;
    end

    // Status is read-only and reserved bits are masked off
    if (reg_write_i) begin
      case (reg_addr_i)
        ACLS_ADDR_BRIDGE_CONTROL: begin
          bc_next = reg_wdata_i & ACLS_BRIDGE_CONTROL_MASK;
        end
        ACLS_ADDR_AUDIO_FIFO_CONTROL: begin
          af_next = reg_wdata_i & ACLS_AUDIO_FIFO_MASK;
        end
        default: begin
        end
      endcase
    end
    next_state.bridge_control = bc_next;
    next_state.audio_fifo_control = af_next;

    if (reg_read_i) begin
      next_state.rvalid = 1'b1;
      case (reg_addr_i)
        ACLS_ADDR_BRIDGE_CONTROL: begin
          next_state.rdata = state.bridge_control;
        end
        ACLS_ADDR_AUDIO_FIFO_CONTROL: begin
          next_state.rdata = state.audio_fifo_control;
        end
        ACLS_ADDR_LINK_STATUS: begin
          next_state.rdata = state.link_status;
        end
        default: begin
          next_state.rdata = ACLS_READ_UNMAPPED;
        end
      endcase
    end

    next_state.fifo_reset =
        (state.audio_fifo_control[ACLS_AF_RESET_ON_TYPE]
         & events_i.audio_type)
      | (state.audio_fifo_control[ACLS_AF_RESET_ON_AIF]
         & events_i.audio_infoframe)
      | (state.audio_fifo_control[ACLS_AF_RESET_ON_AVI]
         & events_i.video_infoframe)
      | (state.audio_fifo_control[ACLS_AF_RESET_ON_ACR]
         & events_i.clock_regen);

    next_state.ctl.tdm_enable = bc_next[ACLS_BC_TDM_ENABLE];
    next_state.ctl.audio_source_local =
        bc_next[ACLS_BC_AUDIO_SOURCE];
    next_state.ctl.extra_channel_enable =
        bc_next[ACLS_BC_EXTRA_CHAN];
    next_state.ctl.tdm_to_parallel_enable =
        af_next[ACLS_AF_TDM_TO_PARALLEL];
    next_state.ctl.use_converter_clock =
        af_next[ACLS_AF_TDM_TO_PARALLEL];
    // Pins only carry video-input audio, so local source disables them
    next_state.ctl.audio_pin_output_enable =
        af_next[ACLS_AF_PIN_OUTPUT]
        & ~bc_next[ACLS_BC_AUDIO_SOURCE];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state.bridge_control     <= ACLS_BRIDGE_CONTROL_RESET;
      state.audio_fifo_control <= ACLS_AUDIO_FIFO_RESET;
      state.link_status        <= ACLS_LINK_STATUS_RESET;
      state.rdata              <= ACLS_READ_UNMAPPED;
      state.rvalid             <= 1'b0;
      state.strap_pending      <= 1'b1;
      state.fifo_reset         <= 1'b0;
      state.ctl                <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o  = state.rdata;
  assign reg_rvalid_o = state.rvalid;
  assign audio_ctl_o  = state.ctl;
  assign fifo_reset_o = state.fifo_reset;

endmodule
`default_nettype wire

/* verification/acls_properties.sv */
// Port checks for the audio config and link status bank
`timescale 1ns/1ps
`default_nettype none
module acls_properties
  import acls_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            reset_i,
  input wire logic            strap_pin_zero_i,
  input wire logic [7:0]      reg_addr_i,
  input wire logic            reg_write_i,
  input wire logic [7:0]      reg_wdata_i,
  input wire logic            reg_read_i,
  input wire acls_live_s      live_i,
  input wire acls_events_s    events_i,
  input wire logic [7:0]      reg_rdata_o,
  input wire logic            reg_rvalid_o,
  input wire acls_audio_ctl_s audio_ctl_o,
  input wire logic            fifo_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic wbc, waf, rst;
  assign wbc = reg_write_i && reg_addr_i == ACLS_ADDR_BRIDGE_CONTROL;
  assign waf = reg_write_i && reg_addr_i == ACLS_ADDR_AUDIO_FIFO_CONTROL;
  assign rst = reg_read_i && reg_addr_i == ACLS_ADDR_LINK_STATUS;
  a_bridge_follows: assert property (
    wbc |=> audio_ctl_o[5:3] == $past(reg_wdata_i[2:0]))
    else $error("bridge bits wrong");
  a_strap_load: assert property (
    $past(reset_i) && !wbc |=> audio_ctl_o[3] == $past(strap_pin_zero_i))
    else $error("strap not loaded");
  a_converter_on: assert property (
    waf |=> audio_ctl_o[2:1] == {2{$past(reg_wdata_i[7])}})
    else $error("converter enable wrong");
  a_pin_gated: assert property (
    audio_ctl_o[0] |-> !audio_ctl_o[4]) else $error("pin output ungated");
  a_fifo_cause: assert property (
    fifo_reset_o |-> $past(|events_i)) else $error("fifo reset uncaused");
  // Status lags the live levels by two cycles; skip reads right after reset
  a_link_ready: assert property (
    rst && !$past(reset_i) |=> reg_rdata_o[7] == $past(live_i.link_ready, 2))
    else $error("link ready wrong");
  a_tx_needs_input: assert property (
    rst && !$past(reset_i) |=> reg_rdata_o[6] == $past(live_i.tx_active &&
    live_i.downstream_locked && live_i.input_valid && live_i.mode_entered, 2))
    else $error("transmit status wrong");
  a_port_idle: assert property (
    rst ##1 !reg_rdata_o[6] |-> reg_rdata_o[5:4] == 2'h0)
    else $error("port mode shown while idle");
  a_read_answers: assert property (
    reg_read_i |=> reg_rvalid_o) else $error("read not answered");
  c_fifo: cover property (fifo_reset_o);
  c_tx: cover property (rst ##1 reg_rdata_o[6]);
  c_pin: cover property (audio_ctl_o[0]);
endmodule
`default_nettype wire

/* verification/acls_partner.sv */
// Video source and downstream receiver status model
`timescale 1ns/1ps
`default_nettype none
module acls_partner
  import acls_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            connect_i,
  input  wire logic            fault_i,
  input  wire acls_port_mode_e mode_i,
  output acls_live_s           live_o
);
  logic [3:0] s = 4'h0;
  // Bring-up order: clock, lock, data, link, mode, then transmit
  always @(posedge clk_i) s <= connect_i ? s + {3'h0, s != 4'hF} : 4'h0;
  // A fault drops input validity only, so transmit may claim too early
  assign live_o = {s > 5, s > 8, s > 7, s > 4 && !fault_i, s > 6,
                   s > 6 ? mode_i : ACLS_PORT_DUAL, s > 3, s > 2,
                   s == 0, s > 1};
endmodule
`default_nettype wire

/* verification/acls_regs_tb.sv */
// Self-checking bench for the audio config and link status bank
`timescale 1ns/1ps
`default_nettype none
module acls_regs_tb;
  import acls_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, wr = 1'b0, rd = 1'b0;
  logic conn = 1'b0, flt = 1'b0, rvalid, frst, strap = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got;
  acls_port_mode_e pmode = ACLS_PORT_DUAL;
  acls_events_s ev = '0;
  acls_live_s live;
  acls_audio_ctl_s ctl;
  int bad_count = 0, check_count = 0;
  acls_regs #(.TMDS_ALWAYS_VALID(1'b0)) acls_regs_inst (.clk_i(clk_i),
    .reset_i(reset_i), .strap_pin_zero_i(strap), .reg_addr_i(addr),
    .reg_write_i(wr), .reg_wdata_i(wdata), .reg_read_i(rd), .live_i(live),
    .events_i(ev), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .audio_ctl_o(ctl), .fifo_reset_o(frst));
  acls_partner acls_partner_inst (.clk_i(clk_i), .connect_i(conn),
    .fault_i(flt), .mode_i(pmode), .live_o(live));
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(logic [7:0] a);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    got = rdata;
    chk("reg_rvalid", {7'h0, rvalid}, 8'h01);
  endtask
  task automatic pulse(logic [3:0] m, logic exp);
    @(posedge clk_i);
    ev <= acls_events_s'(m);
    @(posedge clk_i);
    ev <= '0;
    #1;
    chk("fifo_reset", {7'h0, frst}, {7'h0, exp});
  endtask
  task automatic t_audio();
    rreg(ACLS_ADDR_AUDIO_FIFO_CONTROL);
    chk("audio_fifo_control", got, ACLS_AUDIO_FIFO_RESET);
    rreg(ACLS_ADDR_BRIDGE_CONTROL);
    chk("bridge_control", got, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wreg(ACLS_ADDR_BRIDGE_CONTROL, 8'hF8 | 8'(i));
      chk("audio_ctl", {5'h0, ctl[5:3]}, 8'(i));
    end
    wreg(ACLS_ADDR_AUDIO_FIFO_CONTROL, 8'hFF);
    rreg(ACLS_ADDR_AUDIO_FIFO_CONTROL);
    chk("audio_fifo_control", got, 8'hCF);
    chk("converter", {6'h0, ctl[2:1]}, 8'h03);
    chk("pin_output", {7'h0, ctl[0]}, 8'h00);
    wreg(ACLS_ADDR_BRIDGE_CONTROL, 8'h00);
    chk("pin_output", {7'h0, ctl[0]}, 8'h01);
    $display("audio test done");
  endtask
  task automatic t_fifo();
    for (int k = 0; k < 4; k++) begin
      wreg(ACLS_ADDR_AUDIO_FIFO_CONTROL, 8'h01 << k);
      pulse(~(4'h1 << k), 1'b0);
      pulse(4'h1 << k, 1'b1);
    end
    $display("fifo test done");
  endtask
  task automatic t_status();
    @(posedge clk_i);
    conn <= 1'b1;
    repeat (12) @(posedge clk_i);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      pmode <= acls_port_mode_e'(m);
      repeat (2) @(posedge clk_i);
      rreg(ACLS_ADDR_LINK_STATUS);
      chk("link_status", got, 8'hCD | 8'(m << 4));
    end
    @(posedge clk_i);
    flt <= 1'b1;
    wreg(ACLS_ADDR_LINK_STATUS, 8'hFF);
    rreg(ACLS_ADDR_LINK_STATUS);
    chk("link_status", got, 8'h8D);
    @(posedge clk_i);
    conn <= 1'b0;
    repeat (2) @(posedge clk_i);
    rreg(ACLS_ADDR_LINK_STATUS);
    chk("link_status", got, 8'h02);
    $display("status test done");
  endtask
  task automatic t_strap();
    @(posedge clk_i);
    strap <= 1'b0;
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rreg(ACLS_ADDR_BRIDGE_CONTROL);
    chk("bridge_control", got, 8'h00);
    chk("audio_ctl", {5'h0, ctl[5:3]}, 8'h00);
    rreg(ACLS_ADDR_AUDIO_FIFO_CONTROL);
    chk("audio_fifo_control", got, ACLS_AUDIO_FIFO_RESET);
    $display("strap test done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial forever #12.5 clk_i = ~clk_i;
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    t_audio();
    t_fifo();
    t_status();
    t_strap();
    summarize();
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule
bind acls_regs acls_properties acls_properties_inst (.clk_i(clk_i),
  .reset_i(reset_i), .strap_pin_zero_i(strap_pin_zero_i),
  .reg_addr_i(reg_addr_i), .reg_write_i(reg_write_i),
  .reg_wdata_i(reg_wdata_i), .reg_read_i(reg_read_i), .live_i(live_i),
  .events_i(events_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .audio_ctl_o(audio_ctl_o),
  .fifo_reset_o(fifo_reset_o));
`default_nettype wire
